// ===== crfm_defines.vh
// Constants for the counter relay block: ranges, timing and cycle counts.
// Assumes a 20 MHz system clock; included by bare name.
`ifndef CRFM_DEFINES_VH
`define CRFM_DEFINES_VH
`define CRFM_CLK_HZ 20000000
`define CRFM_GATE_MS 1000
`define CRFM_GATE_CYCLES ((`CRFM_CLK_HZ / 1000) * `CRFM_GATE_MS)
`define CRFM_MIN_PHASE_US 500
`define CRFM_MIN_PHASE_CYCLES ((`CRFM_CLK_HZ / 1000000) * `CRFM_MIN_PHASE_US)
`define CRFM_UPDOWN_MAX 16'h7D00
`define CRFM_FREQ_SP_MAX 16'h03E8
`define CRFM_FREQ_MIN 16'h0004
`define CRFM_ZERO 16'h0000
`define CRFM_VAL_W 16
`endif

// ===== crfm_freq_unit.v
// One frequency counter: counts rising edges over a one second gate.
// Assumes pin is already synchronised to clk; gate length is a parameter.
`timescale 1ns/1ns
`default_nettype none
`include "crfm_defines.vh"
module crfm_freq_unit #(
	parameter GATE_CYCLES = `CRFM_GATE_CYCLES
) (
	input wire clk,
	input wire nrst,
	input wire pin_sync,
	input wire enable,
	input wire clear,
	output reg [15:0] actual,
	output reg in_range
);
	reg [31:0] gate_cnt;
	reg [15:0] pulse_cnt;
	reg pin_last;
	wire rise;
	wire gate_end;
	assign rise = pin_sync & ~pin_last;
	assign gate_end = (gate_cnt == GATE_CYCLES - 1);
	// Back to back gates, latch pulse count at gate end
	always @(posedge clk) begin
		pin_last <= pin_sync;
		if (!nrst || clear || !enable) begin
			gate_cnt <= 32'h0000_0000;
			pulse_cnt <= 16'h0000;
			actual <= `CRFM_ZERO;
			in_range <= 1'b0;
		end else if (gate_end) begin
			gate_cnt <= 32'h0000_0000;
			pulse_cnt <= 16'h0000;
			actual <= pulse_cnt + {15'h0000, rise};
			in_range <= (pulse_cnt + {15'h0000, rise}) >= `CRFM_FREQ_MIN;
		end else begin
			gate_cnt <= gate_cnt + 32'h0000_0001;
			if (rise && pulse_cnt != 16'hFFFF)
				pulse_cnt <= pulse_cnt + 16'h0001;
		end
	end
endmodule // crfm_freq_unit
`default_nettype wire

// ===== crfm_updown_unit.v
// One up/down counter relay with saturation and optional retention.
// Assumes coils are sampled once per program cycle via cycle_en.
`timescale 1ns/1ns
`default_nettype none
`include "crfm_defines.vh"
module crfm_updown_unit (
	input wire clk,
	input wire nrst,
	input wire cycle_en,
	input wire run,
	input wire retentive,
	input wire count_coil,
	input wire direction_coil,
	input wire reset_coil,
	output reg [15:0] actual
);
	reg coil_last;
	// Edge counting with saturation; reset wins
	always @(posedge clk) begin
		if (!nrst) begin
			coil_last <= 1'b0;
			if (!retentive)
				actual <= `CRFM_ZERO;
		end else if (cycle_en) begin
			coil_last <= count_coil;
			if (reset_coil)
				actual <= `CRFM_ZERO;
			else if (!run && !retentive)
				actual <= `CRFM_ZERO;
			else if (run && count_coil && !coil_last) begin
				if (direction_coil) begin
					if (actual != `CRFM_ZERO)
						actual <= actual - 16'h0001;
				end else if (actual < `CRFM_UPDOWN_MAX)
					actual <= actual + 16'h0001;
			end
		end
	end
endmodule // crfm_updown_unit
`default_nettype wire

// ===== crfm_counter_relay.v
// Counter relay top: one up/down counter and two frequency counters.
// Assumes: freq inputs are asynchronous pins; coils come from logic on clk.
// Retention across power loss is modelled by nrst; a retentive up/down count survives it.
`timescale 1ns/1ns
`default_nettype none
`include "crfm_defines.vh"
module crfm_counter_relay #(
	parameter GATE_CYCLES = `CRFM_GATE_CYCLES,
	parameter CYCLE_CYCLES = 16'h0FA0
) (
	input wire clk,
	input wire nrst,
	input wire run,
	input wire updown_retentive,
	input wire [15:0] updown_setpoint,
	input wire count_coil,
	input wire direction_coil,
	input wire reset_coil,
	input wire updown_self_reset,
	input wire freq_input_a,
	input wire freq_input_b,
	input wire freq_enable_coil_a,
	input wire freq_reset_coil_a,
	input wire freq_direction_coil_a,
	input wire freq_enable_coil_b,
	input wire freq_reset_coil_b,
	input wire freq_direction_coil_b,
	input wire [15:0] freq_setpoint_a,
	input wire [15:0] freq_setpoint_b,
	output reg program_cycle,
	output wire [15:0] updown_actual,
	output reg updown_contact,
	output wire [15:0] freq_counter_a,
	output wire [15:0] freq_counter_b,
	output wire freq_valid_a,
	output wire freq_valid_b,
	output reg freq_contact_a,
	output reg freq_contact_b
);
	// Clamp a frequency setpoint into its legal range
	function [15:0] crfm_clamp_sp;
		input [15:0] sp;
		begin
			crfm_clamp_sp = (sp > `CRFM_FREQ_SP_MAX) ? `CRFM_FREQ_SP_MAX : sp;
		end
	endfunction

	reg [15:0] cycle_cnt;
	reg sync_a1;
	reg sync_a2;
	reg sync_b1;
	reg sync_b2;
	reg auto_reset;
	wire cycle_en;
	wire up_reset;
	wire cmp_a;
	wire cmp_b;

	// Program cycle divider, one enable pulse per cycle
	always @(posedge clk) begin
		if (!nrst) begin
			cycle_cnt <= 16'h0000;
			program_cycle <= 1'b0;
		end else if (cycle_cnt == CYCLE_CYCLES - 16'h0001) begin
			cycle_cnt <= 16'h0000;
			program_cycle <= 1'b1;
		end else begin
			cycle_cnt <= cycle_cnt + 16'h0001;
			program_cycle <= 1'b0;
		end
	end
	assign cycle_en = program_cycle;

	// Two flop synchronisers on the fixed pins
	always @(posedge clk) begin
		if (!nrst) begin
			sync_a1 <= 1'b0;
			sync_a2 <= 1'b0;
			sync_b1 <= 1'b0;
			sync_b2 <= 1'b0;
		end else begin
			sync_a1 <= freq_input_a;
			sync_a2 <= sync_a1;
			sync_b1 <= freq_input_b;
			sync_b2 <= sync_b1;
		end
	end

	// Up/down counter, optionally reset by its own contact
	assign up_reset = reset_coil | auto_reset;
	crfm_updown_unit u_updown (
		.clk(clk),
		.nrst(nrst),
		.cycle_en(cycle_en),
		.run(run),
		.retentive(updown_retentive),
		.count_coil(count_coil),
		.direction_coil(direction_coil),
		.reset_coil(up_reset),
		.actual(updown_actual)
	);

	// Contact on reaching setpoint; self reset clears it next cycle
	always @(posedge clk) begin
		if (!nrst) begin
			updown_contact <= 1'b0;
			auto_reset <= 1'b0;
		end else if (cycle_en) begin
			// While the self reset is pending the contact drops, so it lasts one cycle
			updown_contact <= (updown_actual >= updown_setpoint) && !auto_reset;
			auto_reset <= updown_self_reset && (updown_actual >= updown_setpoint)
				&& !auto_reset;
		end
	end

	// Frequency counters; direction coils deliberately unused
	crfm_freq_unit #(.GATE_CYCLES(GATE_CYCLES)) u_freq_a (
		.clk(clk),
		.nrst(nrst),
		.pin_sync(sync_a2),
		.enable(freq_enable_coil_a & run),
		.clear(freq_reset_coil_a),
		.actual(freq_counter_a),
		.in_range(freq_valid_a)
	);
	crfm_freq_unit #(.GATE_CYCLES(GATE_CYCLES)) u_freq_b (
		.clk(clk),
		.nrst(nrst),
		.pin_sync(sync_b2),
		.enable(freq_enable_coil_b & run),
		.clear(freq_reset_coil_b),
		.actual(freq_counter_b),
		.in_range(freq_valid_b)
	);

	// Comparison runs continuously, free of the cycle
	assign cmp_a = (freq_counter_a >= crfm_clamp_sp(freq_setpoint_a));
	assign cmp_b = (freq_counter_b >= crfm_clamp_sp(freq_setpoint_b));

	// Result handed to the diagram once per program cycle
	always @(posedge clk) begin
		if (!nrst) begin
			freq_contact_a <= 1'b0;
			freq_contact_b <= 1'b0;
		end else if (cycle_en) begin
			freq_contact_a <= cmp_a;
			freq_contact_b <= cmp_b;
		end
	end
endmodule // crfm_counter_relay
`default_nettype wire

// ===== crfm_pulse_src.sv
// Square-wave pulse source standing on one frequency input pin.
// Assumes half is given in clk cycles; zero stops the source, holding pin at its current level.
`timescale 1ns/1ns
`default_nettype none
module crfm_pulse_src (
	input wire logic clk,
	input wire logic [15:0] half,
	output logic pin
);
	logic [15:0] cnt = 16'h0000;
	initial pin = 1'b0;
	// Toggle after each phase of half cycles
	always @(posedge clk) begin
		cnt <= (cnt + 16'h0001 >= half) ? 16'h0000 : cnt + 16'h0001;
		if (half != 16'h0000 && cnt + 16'h0001 >= half) pin <= ~pin;
	end
endmodule // crfm_pulse_src
`default_nettype wire

// ===== crfm_counter_relay_chk.sv
// Checker for the counter relay top, bound to its ports.
// Assumes CYCLE_CYCLES of 8 as set by the bench.
`timescale 1ns/1ns
`default_nettype none
module crfm_counter_relay_chk (
	input wire logic clk,
	input wire logic nrst,
	input wire logic run,
	input wire logic reset_coil,
	input wire logic freq_enable_coil_a,
	input wire logic freq_reset_coil_a,
	input wire logic [15:0] freq_setpoint_a,
	input wire logic program_cycle,
	input wire logic [15:0] updown_actual,
	input wire logic updown_contact,
	input wire logic updown_self_reset,
	input wire logic [15:0] freq_counter_a,
	input wire logic freq_contact_a
);
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// Frequency counter clearing and contact handover
	AST_FRST: assert property (freq_reset_coil_a |=> freq_counter_a == 16'h0000)
		else $error("freq a not cleared by reset coil");
	AST_FEN: assert property (!freq_enable_coil_a |=> freq_counter_a == 16'h0000)
		else $error("freq a not zero while disabled");
	AST_CONT: assert property (program_cycle |=> freq_contact_a ==
		($past(freq_counter_a) >= $past(freq_setpoint_a))) else $error("freq a contact wrong");
	AST_CHOLD: assert property (!program_cycle |=> $stable(freq_contact_a))
		else $error("freq a contact moved off cycle");
	AST_PCYC: assert property (program_cycle |=> !program_cycle [*7] ##1 program_cycle)
		else $error("program cycle spacing wrong");
	// Up/down counter reset, hold and range
	AST_UDRST: assert property (program_cycle && reset_coil |=> updown_actual == 16'h0000)
		else $error("up/down reset lost");
	AST_UDHOLD: assert property (run && !program_cycle |=> $stable(updown_actual))
		else $error("up/down moved off cycle");
	AST_SAT: assert property (updown_actual <= 16'h7d00)
		else $error("up/down above range");
	AST_SELF: assert property (updown_self_reset && $rose(updown_contact) |=>
		updown_contact [*7] ##1 !updown_contact) else $error("self reset contact not one cycle");
	C_CONT: cover property (freq_contact_a);
	C_CNT: cover property (updown_actual == 16'h0003);
	C_FRST: cover property (freq_reset_coil_a ##1 freq_counter_a == 16'h0000);
endmodule // crfm_counter_relay_chk
bind crfm_counter_relay crfm_counter_relay_chk chk_inst (.clk, .nrst, .run, .reset_coil,
	.freq_enable_coil_a, .freq_reset_coil_a, .freq_setpoint_a, .program_cycle,
	.updown_actual, .updown_contact, .updown_self_reset, .freq_counter_a, .freq_contact_a);
`default_nettype wire

// ===== crfm_counter_relay_tb.sv
// Self-checking bench for the counter relay top.
// Assumes gate of 200 clk and program cycle of 8 clk.
`timescale 1ns/1ns
`default_nettype none
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_count++; \
	$display("ERROR t=%0t got %h exp %h", $time, a, b); end end
module crfm_counter_relay_tb;
	logic clk = 1'b0, nrst = 1'b0, run = 1'b1, updown_retentive = 1'b0, count_coil = 1'b0;
	logic direction_coil = 1'b0, reset_coil = 1'b0, updown_self_reset = 1'b0;
	logic freq_input_a, freq_input_b, freq_enable_coil_a = 1'b1, freq_enable_coil_b = 1'b1;
	logic freq_reset_coil_a = 1'b0, freq_reset_coil_b = 1'b0, freq_direction_coil_a = 1'b1;
	logic freq_direction_coil_b = 1'b0, program_cycle, updown_contact, freq_valid_a;
	logic freq_valid_b, freq_contact_a, freq_contact_b;
	logic [15:0] updown_setpoint = 16'h0003, freq_setpoint_a = 16'h000a;
	logic [15:0] freq_setpoint_b = 16'h0004, ha = 16'h0000, hb = 16'h0000;
	logic [15:0] updown_actual, freq_counter_a, freq_counter_b;
	int err_count = 0, tests_run = 0;
	// Rows: half a, half b, count a, count b
	logic [15:0] rows [3][4] = '{'{16'h000a, 16'h0019, 16'h000a, 16'h0004},
		'{16'h0019, 16'h000a, 16'h0004, 16'h000a}, '{16'h0005, 16'h0032, 16'h0014, 16'h0002}};
	crfm_counter_relay #(.GATE_CYCLES(200), .CYCLE_CYCLES(16'h0008)) crfm_counter_relay_inst (
		.clk, .nrst, .run, .updown_retentive, .updown_setpoint, .count_coil, .direction_coil,
		.reset_coil, .updown_self_reset, .freq_input_a, .freq_input_b, .freq_enable_coil_a,
		.freq_reset_coil_a, .freq_direction_coil_a, .freq_enable_coil_b, .freq_reset_coil_b,
		.freq_direction_coil_b, .freq_setpoint_a, .freq_setpoint_b, .program_cycle,
		.updown_actual, .updown_contact, .freq_counter_a, .freq_counter_b, .freq_valid_a,
		.freq_valid_b, .freq_contact_a, .freq_contact_b);
	crfm_pulse_src crfm_pulse_src_inst (.clk, .half(ha), .pin(freq_input_a));
	crfm_pulse_src crfm_pulse_src_inst_b (.clk, .half(hb), .pin(freq_input_b));
	// Clock and watchdog
	always #25 clk = ~clk;
	initial begin
		repeat (8000) @(posedge clk);
		err_count++;
		stop_test;
	end
	task stop_test;
		if (err_count == 0 && tests_run > 0) $display("TEST PASSED");
		else $display("TEST FAILED");
		$finish;
	endtask
	// Count coil pulses, each high and low for two program cycles
	task cnt(input int n);
		repeat (n) begin
			count_coil = 1'b1;
			repeat (16) @(negedge clk);
			count_coil = 1'b0;
			repeat (16) @(negedge clk);
		end
	endtask
	// Main sequence
	initial begin
		repeat (2) @(negedge clk);
		nrst = 1'b1;
		for (int i = 0; i < 3; i++) begin
			ha = rows[i][0];
			hb = rows[i][1];
			repeat (450) @(negedge clk);
			`CHK(freq_counter_a, rows[i][2])
			`CHK(freq_counter_b, rows[i][3])
			`CHK(freq_valid_b, rows[i][3] >= 16'h0004)
			`CHK(freq_valid_a, rows[i][2] >= 16'h0004)
			`CHK(freq_contact_b, rows[i][3] >= 16'h0004)
			`CHK(freq_contact_a, rows[i][2] >= 16'h000a)
		end
		freq_reset_coil_a = 1'b1;
		repeat (2) @(negedge clk);
		`CHK(freq_counter_a, 16'h0000)
		freq_reset_coil_a = 1'b0;
		freq_enable_coil_a = 1'b0;
		repeat (450) @(negedge clk);
		`CHK(freq_counter_a, 16'h0000)
		cnt(3);
		`CHK(updown_actual, 16'h0003)
		`CHK(updown_contact, 1'b1)
		direction_coil = 1'b1;
		cnt(1);
		`CHK(updown_actual, 16'h0002)
		direction_coil = 1'b0;
		reset_coil = 1'b1;
		cnt(1);
		reset_coil = 1'b0;
		`CHK(updown_actual, 16'h0000)
		updown_retentive = 1'b1;
		cnt(2);
		nrst = 1'b0;
		repeat (2) @(negedge clk);
		nrst = 1'b1;
		`CHK(updown_actual, 16'h0002)
		updown_self_reset = 1'b1;
		cnt(1);
		`CHK(updown_actual, 16'h0000)
		stop_test;
	end
endmodule // crfm_counter_relay_tb
`default_nettype wire
